// File: design/ccp_pkg.sv
// Purpose: Shared constants for the compare unit and its register slave
// Assumes: 32-bit AXI4-Lite data, word-aligned registers
// Notes: Offsets are byte addresses
package ccp_pkg;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_VALUE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_TIMER_SEL = 8'h10;
	localparam logic [7:0] OFS_STATE = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int MODE_LSB = 0;
	localparam int DUTY_LSB = 4;
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	typedef enum logic [3:0] {
		MODE_OFF = 4'h0,
		MODE_TOGGLE = 4'h2,
		MODE_SET_ON_MATCH = 4'h8,
		MODE_CLR_ON_MATCH = 4'h9,
		MODE_SOFT_IRQ = 4'ha
	} mode_t;
	localparam logic [1:0] PWM_PREFIX = 2'h3;
endpackage

// File: design/ccp_pwm_gen.sv
// Purpose: Pulse-width generator with up to 10-bit duty resolution
// Assumes: Period counter driven from the core clock
// Notes: Duty is reloaded at each period end for glitch-free output
`timescale 1ns/100ps
`default_nettype none
module ccp_pwm_gen #(
	parameter int DUTY_W = 10
) (
	input wire logic aclk, // Core clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic enable, // PWM mode active
	input wire logic [DUTY_W-1:0] duty, // Requested duty count
	output logic pwm_out // Registered PWM level
);
	logic [DUTY_W-1:0] cnt_q, cnt_d, duty_q, duty_d;
	logic out_d;
	always_comb begin
		cnt_d = cnt_q + {{(DUTY_W-1){1'b0}}, 1'b1};
		duty_d = duty_q;
		out_d = 1'b0;
		if (!enable) begin
			cnt_d = '0;
			duty_d = duty;
		end else begin
			if (&cnt_q) begin
				duty_d = duty;
			end
			out_d = (cnt_d < duty_d);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			duty_q <= '0;
			pwm_out <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			duty_q <= duty_d;
			pwm_out <= out_d;
		end
	end
endmodule
`default_nettype wire

// File: design/ccp_compare_unit.sv
// Purpose: Compare/PWM unit with AXI4-Lite registers and match interrupt
// Assumes: Timer counts are synchronous to aclk
// Notes: Capture modes read as inactive in this unit
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Compare value checked every cycle against the selected 16-bit timer.
// - On match output goes high, low, toggles, or follows port latch.
// - Event flag set in the same cycle the pin action lands.
// - Writing zero control forces compare output latch low; port latch kept.
// - Software interrupt mode leaves the pin alone, only raising the event.
// - Event reaches the interrupt line only while its enable is set.
// - No special event trigger output exists on this unit.
// - PWM mode produces a pulse output of up to 10-bit duty resolution.
// - Writing zero control also forces the PWM latch low.
// - Toggle mode flips output on each match and sets the flag.
// - Mode 1000 presets low, sets on match; 1001 presets high, clears.
// - Mode 0000 disables; it resets only if the duty bits are zero too; 11xx selects PWM.
module ccp_compare_unit
	import ccp_pkg::*;
#(
	parameter int TIMER_W = 16,
	parameter int DUTY_W = 10
) (
	input wire logic aclk, // Core clock, 200 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [TIMER_W-1:0] time_base_a, // First timer count
	input wire logic [TIMER_W-1:0] time_base_b, // Second timer count
	input wire logic general_port, // Port data latch for this pin
	input wire logic port_direction_register, // 1 = pin input
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic shared_output_pin, // Pin level
	output logic shared_output_pin_oe, // Pin output enable
	output logic irq // Level interrupt
);
	// Register state
	logic [5:0] ctrl_q, ctrl_d;
	logic [15:0] value_q, value_d;
	logic status_q, status_d;
	logic mask_q, mask_d;
	logic tsel_q, tsel_d;
	logic unit_output_q, unit_output_d;
	logic [TIMER_W-1:0] prev_q, prev_d;
	logic prev_ok_q, prev_ok_d;
	logic pin_d, oe_d, irq_d;
	// Bus state
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d, rd_word;
	// Derived
	logic [3:0] mode;
	logic [TIMER_W-1:0] timer;
	logic is_cmp, owns_pin, is_pwm, is_match, ev, do_wr, do_rd, wr_ok, rd_ok;
	logic ctrl_wr, ctrl_zero_wr, preset;
	logic [31:0] wval;
	logic pwm_level;

	assign mode = ctrl_q[MODE_LSB +: 4];
	assign timer = tsel_q ? time_base_b : time_base_a;
	assign is_pwm = (mode[3:2] == PWM_PREFIX);
	// Mode decode: which codes compare, and which of those own the pin
	always_comb begin
		is_cmp = 1'b0;
		owns_pin = 1'b0;
		case (mode)
			MODE_TOGGLE,
			MODE_SET_ON_MATCH,
			MODE_CLR_ON_MATCH: begin
				is_cmp = 1'b1;
				owns_pin = 1'b1;
			end
			MODE_SOFT_IRQ: begin
				// Matches still count, but the pin stays with the port latch
				is_cmp = 1'b1;
			end
			default: begin
				// Off, capture, PWM and reserved codes never match
				is_cmp = 1'b0;
				owns_pin = 1'b0;
			end
		endcase
	end
	assign is_match = is_cmp && (timer == value_q[TIMER_W-1:0]) &&
		!(prev_ok_q && prev_q == timer);
	assign ev = is_match;

	// The PWM latch clears whenever the mode leaves PWM, a zero control word included
	ccp_pwm_gen #(.DUTY_W(DUTY_W)) u_pwm (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(is_pwm),
		.duty({value_q[7:0], ctrl_q[DUTY_LSB +: 2]}),
		.pwm_out(pwm_level)
	);

	// Bus write capture, either order
	// A write lands once both halves are held and no response is pending
	assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		awready_d = s_axi_awready;
		wready_d = s_axi_wready;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
			awready_d = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
			wready_d = 1'b0;
		end
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
	end
	// Only words up to the timer select take writes; the state word is read-only
	assign wr_ok = (aw_addr_q <= OFS_TIMER_SEL) && (aw_addr_q[1:0] == 2'h0);
	// Strobed byte lanes of the held write word
	always_comb begin
		wval = 32'h0;
		for (int i = 0; i < 4; i++) begin
			wval[i*8 +: 8] = w_strb_q[i] ? w_data_q[i*8 +: 8] : 8'h00;
		end
	end
	assign ctrl_wr = do_wr && (aw_addr_q == OFS_CONTROL) && w_strb_q[0];
	assign ctrl_zero_wr = ctrl_wr && (wval[5:0] == 6'h00);
	assign preset = ctrl_wr && (wval[5:0] != ctrl_q);

	// Register file and compare output
	always_comb begin
		ctrl_d = ctrl_q;
		value_d = value_q;
		mask_d = mask_q;
		tsel_d = tsel_q;
		unit_output_d = unit_output_q;
		if (do_wr) begin
			case (aw_addr_q)
				OFS_CONTROL: begin
					if (w_strb_q[0]) begin
						ctrl_d = wval[5:0];
					end
				end
				OFS_VALUE: begin
					if (w_strb_q[0]) begin
						value_d[7:0] = wval[7:0];
					end
					if (w_strb_q[1]) begin
						value_d[15:8] = wval[15:8];
					end
				end
				OFS_MASK: begin
					if (w_strb_q[0]) begin
						mask_d = wval[0];
					end
				end
				OFS_TIMER_SEL: begin
					if (w_strb_q[0]) begin
						tsel_d = wval[0];
					end
				end
				default: begin
				end
			endcase
		end
		if (ev) begin
			case (mode)
				MODE_TOGGLE: unit_output_d = !unit_output_q;
				MODE_SET_ON_MATCH: unit_output_d = 1'b1;
				MODE_CLR_ON_MATCH: unit_output_d = 1'b0;
				default: unit_output_d = unit_output_q;
			endcase
		end
		// Presets follow the match action, so a mode change decides the latch
		if (preset) begin
			case (wval[3:0])
				MODE_SET_ON_MATCH: unit_output_d = 1'b0;
				MODE_CLR_ON_MATCH: unit_output_d = 1'b1;
				default: unit_output_d = unit_output_q;
			endcase
		end
		// A zero control word beats both, so the compare latch always reads low
		if (ctrl_zero_wr) begin
			unit_output_d = 1'b0;
		end
	end

	// Match flag: a one written clears it, but a match in that same cycle wins
	always_comb begin
		status_d = status_q;
		if (do_wr && (aw_addr_q == OFS_STATUS) && w_strb_q[0] && wval[0]) begin
			status_d = 1'b0;
		end
		if (ev) begin
			status_d = 1'b1;
		end
	end

	// Match history so a held timer value does not retrigger
	always_comb begin
		prev_d = timer;
		prev_ok_d = is_cmp;
	end

	// Pin mux: compare latch, PWM, or port latch
	always_comb begin
		oe_d = !port_direction_register;
		if (is_pwm) begin
			pin_d = pwm_level;
		end else if (owns_pin) begin
			pin_d = unit_output_d;
		end else begin
			pin_d = general_port;
		end
		irq_d = status_d && mask_q;
	end

	// Reads: the word is decoded from the address as it is taken
	always_comb begin
		rd_word = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			OFS_CONTROL: rd_word = {26'h0, ctrl_q};
			OFS_VALUE: rd_word = {16'h0, value_q};
			OFS_STATUS: rd_word = {31'h0, status_q};
			OFS_MASK: rd_word = {31'h0, mask_q};
			OFS_TIMER_SEL: rd_word = {31'h0, tsel_q};
			OFS_STATE: rd_word = {30'h0, is_pwm ? pwm_level : unit_output_q, is_match};
			default: rd_ok = 1'b0;
		endcase
	end
	assign do_rd = s_axi_arvalid && s_axi_arready;
	always_comb begin
		arready_d = s_axi_arready;
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		if (do_rd) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = rd_word;
			rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CONTROL_RESET;
			value_q <= VALUE_RESET;
			status_q <= 1'b0;
			mask_q <= 1'b0;
			tsel_q <= 1'b0;
			unit_output_q <= 1'b0;
			prev_q <= '0;
			prev_ok_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			shared_output_pin <= 1'b0;
			shared_output_pin_oe <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			value_q <= value_d;
			status_q <= status_d;
			mask_q <= mask_d;
			tsel_q <= tsel_d;
			unit_output_q <= unit_output_d;
			prev_q <= prev_d;
			prev_ok_q <= prev_ok_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
			shared_output_pin <= pin_d;
			shared_output_pin_oe <= oe_d;
			irq <= irq_d;
		end
	end
endmodule
`default_nettype wire

// File: dv/ccp_unit_monitor.sv
// Purpose: Port checks of the compare unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto the unit below the module
`timescale 1ns/100ps
`default_nettype none
module ccp_unit_monitor (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset
	input wire logic port_direction_register, // Direction
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic shared_output_pin_oe, // Pin enable
	input wire logic irq // Interrupt
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !shared_output_pin_oe)
		else $error("output active after reset");
	a_oe_from_dir: assert property ($past(aresetn) |->
		shared_output_pin_oe == !$past(port_direction_register))
		else $error("pin enable not inverse of direction");
	a_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("second write accepted");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_irq_by_write: assert property ($fell(irq) |->
		s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("interrupt fell without a write");
	a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response not retired");
	a_rresp_done: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready)
		else $error("read response not retired");
endmodule
bind ccp_compare_unit ccp_unit_monitor ccp_unit_monitor_inst (.aclk, .aresetn,
	.port_direction_register, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .shared_output_pin_oe, .irq);
`default_nettype wire

// File: dv/ccp_pin_load.sv
// Purpose: Board load on the shared output pin
// Assumes: Weak pull-down on the trace
// Notes: Undriven pad falls to the pull level
`timescale 1ns/100ps
`default_nettype none
module ccp_pin_load (
	input wire logic drive, // Unit level
	input wire logic drive_oe, // Unit drives
	output logic pad // Pad level
);
	assign pad = drive_oe ? drive : 1'h0;
endmodule
`default_nettype wire

// File: dv/ccp_compare_unit_test.sv
// Purpose: Self-checking bench for the compare unit
// Assumes: Timers step on aclk edges
// Notes: Pad is seen through the pin load
`timescale 1ns/100ps
`default_nettype none
module ccp_compare_unit_test;
	import ccp_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, general_port = 1'h0, port_direction_register = 1'h1;
	logic [15:0] time_base_a = 16'h0, time_base_b = 16'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic shared_output_pin, shared_output_pin_oe, irq, pad;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] rsv [3] = '{4'h1, 4'h3, 4'hb};
	int error_cnt = 0, checks = 0, cyc = 0, n, hi;
	ccp_compare_unit ccp_compare_unit_inst (.aclk, .aresetn, .time_base_a, .time_base_b,
		.general_port, .port_direction_register, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_output_pin, .shared_output_pin_oe,
		.irq);
	ccp_pin_load ccp_pin_load_inst (.drive(shared_output_pin), .drive_oe(shared_output_pin_oe),
		.pad);
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task test_done;
		$display("Checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		chk("bresp", 32'(s_axi_bresp), 32'(er));
		s_axi_bready <= 1'h0;
		// One idle edge keeps the next request apart from this release
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rv = s_axi_rdata;
		chk("rresp", 32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk("register", rv, e);
	endtask
	// Selected timer climbs onto v, stalls there, then moves on; the other never matches
	// The stall is six cycles long, so a retriggering toggle would end where it began
	task hit(input logic sel, input logic [15:0] v);
		logic [15:0] x;
		for (int i = 0; i < 10; i++) begin
			x = v + 16'(i > 7) - 16'(i < 2);
			time_base_a <= sel ? ~x : x;
			time_base_b <= sel ? x : ~x;
			@(posedge aclk);
		end
		repeat (2) @(posedge aclk);
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		port_direction_register <= 1'h0;
		for (n = 0; n < 6; n++) rc(8'(4 * n), 32'h0);
		chk("oe", 32'(shared_output_pin_oe), 32'h1);
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, RESP_SLVERR);
		chk("unmapped", rv, 32'h0);
		s_axi_wstrb <= 4'h1;
		wr(OFS_VALUE, 32'hffff);
		s_axi_wstrb <= 4'hf;
		rc(OFS_VALUE, 32'h00ff);
		wr(OFS_VALUE, 32'h1234);
		wr(OFS_CONTROL, 32'(MODE_TOGGLE));
		hit(1'h0, 16'h1234);
		chk("toggle", 32'(pad), 32'h1);
		rc(OFS_STATUS, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(OFS_MASK, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq", 32'(irq), 32'h1);
		wr(OFS_STATUS, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq clear", 32'(irq), 32'h0);
		wr(OFS_TIMER_SEL, 32'h1);
		for (n = 0; n < 2; n++) begin
			wr(OFS_VALUE, 32'h5a00 - 32'(n));
			wr(OFS_CONTROL, 32'(MODE_SET_ON_MATCH) + 32'(n));
			repeat (2) @(posedge aclk);
			chk("preset", 32'(pad), 32'(n));
			hit(1'h1, 16'h5a00 - 16'(n));
			chk("forced", 32'(pad), 32'(1 - n));
		end
		wr(OFS_CONTROL, 32'(MODE_OFF));
		wr(OFS_CONTROL, 32'(MODE_CLR_ON_MATCH));
		rc(OFS_STATE, 32'h2);
		general_port <= 1'h1;
		wr(OFS_CONTROL, 32'h0);
		rc(OFS_STATE, 32'h0);
		chk("port latch", 32'(pad), 32'h1);
		wr(OFS_STATUS, 32'h1);
		wr(OFS_VALUE, 32'h0777);
		wr(OFS_CONTROL, 32'(MODE_SOFT_IRQ));
		hit(1'h1, 16'h0777);
		chk("soft pin", 32'(pad), 32'h1);
		chk("soft irq", 32'(irq), 32'h1);
		general_port <= 1'h0;
		wr(OFS_STATUS, 32'h1);
		chk("follow", 32'(pad), 32'h0);
		for (n = 0; n < 3; n++) begin
			wr(OFS_CONTROL, 32'(rsv[n]));
			hit(1'h1, 16'h0777);
			rc(OFS_STATUS, 32'h0);
		end
		wr(OFS_VALUE, 32'h40);
		wr(OFS_CONTROL, 32'h1c);
		repeat (1100) @(posedge aclk);
		hi = 0;
		repeat (1024) begin
			@(posedge aclk);
			hi += int'(pad === 1'h1);
		end
		chk("duty", 32'(hi), 32'h101);
		wr(OFS_CONTROL, 32'h0);
		rc(OFS_STATE, 32'h0);
		port_direction_register <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("oe off", 32'(shared_output_pin_oe), 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
